// [include/ssc_pkg.sv]
`default_nettype none
package ssc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_FRAME_RATE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PORT_ROLE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA       = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE   = 8'h10;

  // reset values
  localparam logic [15:0] RST_FRAME_RATE = 16'h0000;
  localparam logic [3:0]  RST_PORT_ROLE  = 4'h0;
  localparam logic [7:0]  RST_PRESCALE   = 8'h00;

  // status bit positions
  localparam int unsigned ST_TX_EMPTY = 0;
  localparam int unsigned ST_TX_NFULL = 1;
  localparam int unsigned ST_RX_NEMPTY = 2;
  localparam int unsigned ST_BUSY     = 4;

  // frame format codes
  localparam logic [1:0] FMT_FOUR_WIRE   = 2'h0;
  localparam logic [1:0] FMT_FRAME_PULSE = 2'h1;
  localparam logic [1:0] FMT_CMD_RESP    = 2'h2;

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input synchroniser
  localparam int unsigned SYNC_N    = 3;
  localparam int unsigned PIN_CLK   = 2;
  localparam int unsigned PIN_FRAME = 1;
  localparam int unsigned PIN_DATA  = 0;

  typedef struct packed {
    logic [7:0] rate;
    logic       clock_phase;
    logic       clock_polarity;
    logic [1:0] frame_format;
    logic [3:0] word_size_select;
  } ssc_cr0_s;

  typedef struct packed {
    logic slave_output_disable;
    logic role_select;
    logic port_enable;
    logic loopback;
  } ssc_cr1_s;

  typedef struct packed {
    logic serial_clock_in;
    logic frame_in;
    logic data_in;
  } ssc_pins_in_s;

  typedef struct packed {
    logic serial_clock_pin;
    logic serial_clock_oe_n;
    logic frame_out;
    logic frame_oe_n;
    logic serial_data_out_pin;
    logic data_oe_n;
  } ssc_pins_out_s;

  typedef enum logic [1:0] {
    SC_IDLE,
    SC_SHIFT,
    SC_TAIL
  } ssc_state_e;

endpackage
`default_nettype wire

// [logic/ssc_rate_div.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_rate_div
  import ssc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [7:0] prescale,
  input  wire logic [7:0] rate,
  output var  logic       half_tick
);

  logic [6:0] pre_cnt_q;
  logic [7:0] rate_cnt_q;
  logic [6:0] pre_half;
  logic       pre_wrap;

  // half bit period is prescale/2 * (1 + rate); odd prescale rounds down, zero or one is clamped to 2
  assign pre_half = (prescale[7:1] == 7'h00) ? 7'h01 : prescale[7:1];
  assign pre_wrap = (pre_cnt_q == pre_half - 7'h01);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_cnt_q  <= 7'h00;
      rate_cnt_q <= 8'h00;
      half_tick  <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        pre_cnt_q  <= 7'h00;
        rate_cnt_q <= 8'h00;
        half_tick  <= 1'b0;
      end
      else
      begin
        half_tick <= 1'b0;
        if (pre_wrap)
        begin
          pre_cnt_q <= 7'h00;
          if (rate_cnt_q == rate) // RL1
          begin
            rate_cnt_q <= 8'h00;
            half_tick  <= 1'b1;
          end
          else
          begin
            rate_cnt_q <= rate_cnt_q + 8'h01;
          end
        end
        else
        begin
          pre_cnt_q <= pre_cnt_q + 7'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [logic/ssc_port_ctrl.sv]
// Summary of operation
// RL1 - bit rate is system clock over prescale times one plus rate factor
// RL2 - software writes only even prescale 2..254; rate factor 0..255
// RL3 - in slave role software sets rate factor 0 and prescale 2
// RL4 - four-wire format samples on first edge if phase 0, second if 1
// RL5 - four-wire format idles clock low for polarity 0, high for 1
// RL6 - two-bit field picks four-wire, frame-pulse or command/response format
// RL7 - word length is size code plus one, 4 to 16 bits
// RL8 - slave output disable bit turns off data driver in slave role
// RL9 - role bit 0 makes the port clock master, 1 a clocked slave
// RL10 - loopback feeds transmit shifter output into receive shifter input
// RL11 - unused upper transmit bits ignored; receive data right justified
// RL12 - transfers run only while the port enable bit is set
// RL13 - software changes settings only while the port is disabled
`timescale 1ns/100ps
`default_nettype none
module ssc_port_ctrl
  import ssc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [DATA_W-1:0]   s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire ssc_pins_in_s        pins_in,
  output var  ssc_pins_out_s       pins_out
);

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == OFF_FRAME_RATE) || (a == OFF_PORT_ROLE) || (a == OFF_DATA) ||
              (a == OFF_STATUS) || (a == OFF_PRESCALE);
  endfunction

  function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] nw,
                                                   input logic [3:0]        strb);
    for (int i = 0; i < 4; i++)
      old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    apply_strb = old;
  endfunction

  ssc_cr0_s          cr0_q;
  ssc_cr1_s          cr1_q;
  logic [7:0]        pre_q;
  logic [WORD_W-1:0] tx_q;
  logic              tx_full_q;
  logic [WORD_W-1:0] rx_q;
  logic              rx_valid_q;

  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_fire;
  logic [DATA_W-1:0] wr_old;
  logic [DATA_W-1:0] wr_word;
  logic              rd_fire;
  logic [DATA_W-1:0] rd_word;

  ssc_state_e        state_q;
  logic              lvl_q;
  logic [3:0]        bit_cnt_q;
  logic [WORD_W-1:0] tx_sh_q;
  logic [WORD_W-1:0] rx_sh_q;
  logic              dout_q;

  logic [2:0]        sync1_q;
  logic [2:0]        sync2_q;
  logic [2:0]        sync3_q;
  logic [2:0]        filt_q;
  logic [2:0]        filt_prev_q;

  logic              go;
  logic              master;
  logic              cpha;
  logic              cpol;
  logic              half_tick;
  logic              lead;
  logic              trail;
  logic              smp;
  logic              launch;
  logic              start;
  logic              abort;
  logic              din;
  logic              last_bit;
  logic [WORD_W-1:0] tx_aligned;
  logic              s_lvl;
  logic              s_lvl_prev;

  assign go     = cr1_q.port_enable;     // RL12
  assign master = !cr1_q.role_select;    // RL9
  // RL6
  assign cpha = (cr0_q.frame_format == FMT_FOUR_WIRE) ? cr0_q.clock_phase :
                (cr0_q.frame_format == FMT_FRAME_PULSE); // RL4
  assign cpol = (cr0_q.frame_format == FMT_FOUR_WIRE) && cr0_q.clock_polarity; // RL5

  // ---------------- register bus ----------------
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    wr_old = '0;
    unique case (awaddr_q)
      OFF_FRAME_RATE: wr_old = {16'h0000, cr0_q};
      OFF_PORT_ROLE:  wr_old = {28'h0000000, cr1_q};
      OFF_PRESCALE:   wr_old = {24'h000000, pre_q};
      default:        wr_old = '0;
    endcase
    wr_word = apply_strb(wr_old, wdata_q, wstrb_q);
  end

  always_comb
  begin
    rd_word = '0;
    unique case (s_axi_araddr)
      OFF_FRAME_RATE: rd_word = {16'h0000, cr0_q};
      OFF_PORT_ROLE:  rd_word = {28'h0000000, cr1_q};
      OFF_PRESCALE:   rd_word = {24'h000000, pre_q};
      OFF_DATA:       rd_word = {16'h0000, rx_q};
      OFF_STATUS:
      begin
        rd_word[ST_TX_EMPTY]  = !tx_full_q;
        rd_word[ST_TX_NFULL]  = !tx_full_q;
        rd_word[ST_RX_NEMPTY] = rx_valid_q;
        rd_word[ST_BUSY]      = (state_q != SC_IDLE) || tx_full_q;
      end
      default:        rd_word = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_ok(awaddr_q) && awaddr_q != OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cr0_q <= RST_FRAME_RATE;
      cr1_q <= RST_PORT_ROLE;
      pre_q <= RST_PRESCALE;
    end
    else if (ce && wr_fire)
    begin
      // settings are taken at once; the port does not guard a change mid-frame
      if (awaddr_q == OFF_FRAME_RATE)
        cr0_q <= wr_word[15:0];
      if (awaddr_q == OFF_PORT_ROLE)
        cr1_q <= wr_word[3:0];
      if (awaddr_q == OFF_PRESCALE)
        pre_q <= wr_word[7:0];
    end
  end

  // single-word transmit and receive holding; a write while full is dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_q       <= '0;
      tx_full_q  <= 1'b0;
      rx_q       <= '0;
      rx_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      if (start)
        tx_full_q <= 1'b0;
      if (wr_fire && awaddr_q == OFF_DATA && !tx_full_q)
      begin
        tx_q      <= wdata_q[WORD_W-1:0];
        tx_full_q <= 1'b1;
      end
      if (rd_fire && s_axi_araddr == OFF_DATA)
        rx_valid_q <= 1'b0;
      if (smp && last_bit)
      begin
        rx_q       <= {rx_sh_q[WORD_W-2:0], din}; // RL11
        rx_valid_q <= 1'b1;
      end
    end
  end

  // ---------------- pin inputs ----------------
  generate
    for (genvar i = 0; i < SYNC_N; i++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          sync1_q[i]     <= 1'b0;
          sync2_q[i]     <= 1'b0;
          sync3_q[i]     <= 1'b0;
          filt_q[i]      <= (i == PIN_FRAME);
          filt_prev_q[i] <= (i == PIN_FRAME);
        end
        else if (ce)
        begin
          sync1_q[i]     <= pins_in[i];
          sync2_q[i]     <= sync1_q[i];
          sync3_q[i]     <= sync2_q[i];
          filt_prev_q[i] <= filt_q[i];
          if (sync2_q[i] == sync3_q[i])
            filt_q[i] <= sync3_q[i];
        end
      end
    end
  endgenerate

  ssc_rate_div u_rate_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .run       (go && master),
    .prescale  (pre_q),
    .rate      (cr0_q.rate),
    .half_tick (half_tick)
  );

  // ---------------- serial engine ----------------
  assign din        = cr1_q.loopback ? dout_q : filt_q[PIN_DATA]; // RL10
  assign last_bit   = (bit_cnt_q == cr0_q.word_size_select);     // RL7
  assign tx_aligned = tx_q << (4'hF - cr0_q.word_size_select);   // RL11
  assign s_lvl      = filt_q[PIN_CLK] ^ cpol;
  assign s_lvl_prev = filt_prev_q[PIN_CLK] ^ cpol;

  always_comb
  begin
    lead  = 1'b0;
    trail = 1'b0;
    start = 1'b0;
    abort = !go;
    if (master)
    begin
      if (state_q == SC_SHIFT && half_tick)
      begin
        lead  = !lvl_q;
        trail = lvl_q;
      end
      start = go && half_tick && tx_full_q && state_q == SC_IDLE;
    end
    else
    begin
      if (state_q == SC_SHIFT)
      begin
        lead  = s_lvl && !s_lvl_prev;
        trail = !s_lvl && s_lvl_prev;
      end
      if (cr0_q.frame_format == FMT_FRAME_PULSE)
        start = go && state_q == SC_IDLE && filt_q[PIN_FRAME] && !filt_prev_q[PIN_FRAME];
      else
      begin
        start = go && state_q == SC_IDLE && !filt_q[PIN_FRAME] && filt_prev_q[PIN_FRAME];
        abort = !go || (filt_q[PIN_FRAME] && state_q != SC_IDLE);
      end
    end
    smp    = cpha ? trail : lead;  // RL4
    launch = cpha ? lead : trail;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q   <= SC_IDLE;
      lvl_q     <= 1'b0;
      bit_cnt_q <= 4'h0;
      tx_sh_q   <= '0;
      rx_sh_q   <= '0;
      dout_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (abort) // RL12
      begin
        state_q <= SC_IDLE;
        lvl_q   <= 1'b0;
      end
      else if (start)
      begin
        state_q   <= SC_SHIFT;
        lvl_q     <= 1'b0;
        bit_cnt_q <= 4'h0;
        rx_sh_q   <= '0;
        if (!cpha)
        begin
          dout_q  <= tx_aligned[WORD_W-1];
          tx_sh_q <= {tx_aligned[WORD_W-2:0], 1'b0};
        end
        else
          tx_sh_q <= tx_aligned;
      end
      else
      begin
        if (state_q == SC_SHIFT && master && half_tick)
          lvl_q <= !lvl_q; // RL9
        if (launch)
        begin
          dout_q  <= tx_sh_q[WORD_W-1];
          tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
        end
        if (smp)
        begin
          rx_sh_q   <= {rx_sh_q[WORD_W-2:0], din};
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (last_bit)
            state_q <= master ? SC_TAIL : SC_IDLE;
        end
        // master returns the clock to idle before releasing the frame
        if (state_q == SC_TAIL && half_tick)
        begin
          if (lvl_q)
            lvl_q <= 1'b0;
          else
            state_q <= SC_IDLE;
        end
      end
    end
  end

  // pins are registered: one cycle behind the engine, same for every pin
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins_out <= '{serial_clock_pin: 1'b0, serial_clock_oe_n: 1'b1, frame_out: 1'b1,
                    frame_oe_n: 1'b1, serial_data_out_pin: 1'b0, data_oe_n: 1'b1};
    end
    else if (ce)
    begin
      pins_out.serial_clock_pin    <= cpol ^ lvl_q; // RL5
      pins_out.serial_clock_oe_n   <= !(go && master); // RL9
      pins_out.frame_oe_n          <= !(go && master);
      pins_out.serial_data_out_pin <= dout_q;
      if (cr0_q.frame_format == FMT_FRAME_PULSE)
        pins_out.frame_out <= (state_q == SC_SHIFT) && (bit_cnt_q == 4'h0);
      else
        pins_out.frame_out <= (state_q == SC_IDLE);
      if (master)
        pins_out.data_oe_n <= !go;
      else
        pins_out.data_oe_n <= !(go && state_q != SC_IDLE && !cr1_q.slave_output_disable); // RL8
    end
  end

endmodule
`default_nettype wire

// [logic/unused_placeholder_none.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [tb/ssc_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_chk
  import ssc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              s_axi_awvalid,
  input  wire logic              s_axi_awready,
  input  wire logic              s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic              s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire ssc_pins_out_s     pins_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  a_reset_idle: assert property ($rose(rst_n) |-> pins_out.data_oe_n && pins_out.serial_clock_oe_n)
    else $error("pins driven after reset");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($fell(pins_out.frame_out));
endmodule
bind ssc_port_ctrl ssc_chk chk_i (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pins_out(pins_out));
`default_nettype wire

// [tb/ssc_peer.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_peer
(
  input  wire logic        clk,
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic        cpha,
  input  wire logic [15:0] tx_word,
  output var  logic        miso,
  output var  logic [15:0] rx_word,
  output var  int          edges,
  output var  int          half
);
  logic        last_sck = 1'b0;
  logic        last_sel = 1'b1;
  logic        odd      = 1'b1;
  logic [15:0] sh       = 16'h0000;
  int          cnt      = 0;
  initial
  begin
    miso  = 1'b0;
    edges = 0;
    half  = 0;
  end
  always @(posedge clk)
  begin
    last_sck <= sck;
    last_sel <= sel_n;
    cnt      <= cnt + 1;
    if (sck !== last_sck)
      edges <= edges + 1;
    if (sel_n)
    begin
      odd  <= 1'b1;
      sh   <= tx_word;
      // released line toggles so a stale bit cannot pass
      miso <= ~miso;
    end
    else if (last_sel && !cpha)
    begin
      miso <= sh[15];
      sh   <= sh << 1;
    end
    else if (sck !== last_sck)
    begin
      odd  <= ~odd;
      half <= cnt + 1;
      cnt  <= 0;
      if (odd ^ cpha)
        rx_word <= {rx_word[14:0], mosi};
      else
      begin
        miso <= sh[15];
        sh   <= sh << 1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
  import ssc_pkg::*;
;
  localparam logic [33:0] ALL = {2'h3, 32'hFFFFFFFF};
  logic                clk, rst_n, miso, pcpha, fss_n;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic [DATA_W-1:0]   wdata, rdata, rd_v, v;
  logic                awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp;
  ssc_pins_out_s       pins_out;
  ssc_pins_in_s        pins_in;
  logic [15:0]         ptx, prx;
  logic [31:0]         seed;
  logic [67:0]         e;
  logic [67:0]         rq[$];
  logic [1:0]          bq[$];
  int                  edges, half, fail_count, n_compared, i, m;
  assign pins_in = {1'b0, fss_n, miso};
  ssc_port_ctrl uut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_in(pins_in), .pins_out(pins_out));
  ssc_peer peer (.clk(clk), .sck(pins_out.serial_clock_pin), .sel_n(pins_out.frame_out),
    .mosi(pins_out.serial_data_out_pin), .cpha(pcpha), .tx_word(ptx), .miso(miso), .rx_word(prx),
    .edges(edges), .half(half));
  task check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("mismatches %0d of %0d compared", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task timeout;
    fail_count++;
    test_done();
  endtask
  // loops end on a blocking flag: a ready set by nonblocking still reads old here
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int   k;
    logic done;
    done = 1'b0;
    @(posedge clk);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 300 && !done; k++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      timeout();
  endtask
  task rd(input logic [7:0] a, input logic [33:0] mk, input logic [33:0] x);
    int   k;
    logic done;
    done = 1'b0;
    @(posedge clk);
    rq.push_back({mk, x});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 300 && !done; k++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        rd_v = rdata;
        done = 1'b1;
      end
    end
    if (!done)
      timeout();
  endtask
  always @(posedge clk)
  begin
    if (rvalid && rready)
    begin
      e = rq.pop_front();
      check({rresp, rdata} & e[67:34], e[33:0]);
    end
    if (bvalid && bready)
      check({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  task xfer(input logic [1:0] f, input logic [3:0] sz, input logic pol, pha, lb, input logic [7:0] r);
    logic [15:0] t, p, mk;
    int          k;
    t  = 16'($random(seed));
    p  = 16'($random(seed));
    mk = 16'hFFFF >> (4'hF - sz);
    wr(OFF_PORT_ROLE, 32'h0, RESP_OKAY);
    wr(OFF_FRAME_RATE, {16'h0, r, pha, pol, f, sz}, RESP_OKAY);
    pcpha <= pha;
    ptx   <= p << (4'hF - sz);
    wr(OFF_PORT_ROLE, {28'h0, 3'b001, lb}, RESP_OKAY);
    if (f == FMT_FOUR_WIRE)
      check({33'h0, pins_out.serial_clock_pin}, {33'h0, pol});
    // upper bits carry junk that must never reach the wire
    wr(OFF_DATA, {16'hA5C3, t}, RESP_OKAY);
    rd_v = 32'h0;
    for (k = 0; k < 400 && (rd_v & 32'h14) !== 32'h4; k++)
      rd(OFF_STATUS, 34'h0, 34'h0);
    if ((rd_v & 32'h14) !== 32'h4)
      timeout();
    rd(OFF_STATUS, {2'h3, 32'h17}, {RESP_OKAY, 32'h7});
    rd(OFF_DATA, ALL, {RESP_OKAY, 16'h0, (lb ? t : p) & mk});
    rd(OFF_STATUS, {2'h3, 32'h4}, {RESP_OKAY, 32'h0});
    if (!lb)
    begin
      check({18'h0, prx & mk}, {18'h0, t & mk});
      check(34'(half), 34'(10 * (1 + r)));
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    seed = 32'h0C00E156;
    fail_count = 0;
    n_compared = 0;
    {rst_n, awvalid, wvalid, bready, arvalid, rready, pcpha} <= 7'h00;
    {awaddr, araddr, wdata, ptx} <= '0;
    fss_n <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_FRAME_RATE, ALL, {RESP_OKAY, 32'h0});
    rd(OFF_PORT_ROLE, ALL, {RESP_OKAY, 32'h0});
    rd(OFF_PRESCALE, ALL, {RESP_OKAY, 32'h0});
    rd(8'h14, ALL, {RESP_SLVERR, 32'h0});
    wr(OFF_STATUS, 32'h0, RESP_SLVERR);
    v = $random(seed);
    wr(OFF_FRAME_RATE, v, RESP_OKAY);
    rd(OFF_FRAME_RATE, ALL, {RESP_OKAY, 16'h0, v[15:0]});
    wr(OFF_PRESCALE, 32'h14, RESP_OKAY);
    rd(OFF_PRESCALE, ALL, {RESP_OKAY, 32'h14});
    for (i = 0; i < 4; i++)
      xfer(FMT_FOUR_WIRE, 4'(3 + 4 * i), i[1], i[0], 1'b0, 8'($random(seed) & 1));
    for (i = 0; i < 3; i++)
      xfer(2'(i), 4'hF - 4'(i), 1'b0, 1'b0, 1'b1, 8'h1);
    wr(OFF_PRESCALE, 32'h2, RESP_OKAY);
    wr(OFF_FRAME_RATE, 32'h000F, RESP_OKAY);
    wr(OFF_PORT_ROLE, 32'hE, RESP_OKAY);
    // select low starts a slave frame; no clock comes, so it stays open
    fss_n <= 1'b0;
    repeat (8) @(posedge clk);
    check({32'h0, pins_out.data_oe_n, pins_out.serial_clock_oe_n}, {32'h0, 2'b11});
    wr(OFF_PORT_ROLE, 32'h6, RESP_OKAY);
    repeat (3) @(posedge clk);
    check({33'h0, pins_out.data_oe_n}, 34'h0);
    fss_n <= 1'b1;
    repeat (8) @(posedge clk);
    check({33'h0, pins_out.data_oe_n}, 34'h1);
    wr(OFF_PORT_ROLE, 32'h2, RESP_OKAY);
    repeat (3) @(posedge clk);
    check({32'h0, pins_out.serial_clock_oe_n, pins_out.frame_oe_n}, 34'h0);
    wr(OFF_PORT_ROLE, 32'h0, RESP_OKAY);
    m = edges;
    wr(OFF_DATA, 32'h1234, RESP_OKAY);
    repeat (200) @(posedge clk);
    check(34'(edges), 34'(m));
    test_done();
  end
endmodule
`default_nettype wire
